/* File: design/scdl_decoder.sv */
// one-hot channel decoder for the stored command word
// assumes a pure combinational context; codes at or above the channel count select nothing
`timescale 1ns/1ps
module scdl_decoder
    import scdl_pkg::*;
#(
    parameter int CHANNELS = SCDL_CHANNELS
)(
    input wire logic [SCDL_WORD_W-1:0] i_word,
    input wire logic i_enable,
    output logic [CHANNELS-1:0] o_onehot
);
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_ch
            // out-of-range codes fall through so no channel fires on a bad word
            assign o_onehot[g] = i_enable && (i_word == SCDL_WORD_W'(g));
        end
    endgenerate
endmodule

/* File: design/scdl_top.sv */
// stage command decoder latch: holding register, complement echo, decoder, command latches
// assumes flight computer signals are on i_clock; ground and emergency pins are asynchronous
`timescale 1ns/1ps
module scdl_top
    import scdl_pkg::*;
#(
    parameter int CHANNELS = SCDL_CHANNELS
)(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire scdl_cmd_s i_cmd,
    input wire logic i_fire_strobe,
    input wire logic i_ground_reset,
    input wire logic i_emergency_cutoff,
    output logic [SCDL_WORD_W-1:0] o_echo,
    output logic o_echo_valid,
    output logic [CHANNELS-1:0] o_command,
    output logic o_all_reset,
    output logic o_engine_shutdown
);
    logic [SCDL_WORD_W-1:0] word_ff;
    logic echo_valid_ff;
    logic [CHANNELS-1:0] latch_ff;
    logic [CHANNELS-1:0] nxt_pulse;
    logic gnd_meta_ff;
    logic gnd_sync_ff;
    logic emg_meta_ff;
    logic emg_sync_ff;
    logic shutdown_ff;
    logic all_reset_ff;
    logic [CHANNELS:0] series_chain;
    logic word_accept;

    // ground unlatch pin passes two flops before use
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            gnd_meta_ff <= 1'b0;
            gnd_sync_ff <= 1'b0;
        end
        else
        begin
            gnd_meta_ff <= i_ground_reset;
            gnd_sync_ff <= gnd_meta_ff;
        end
    end

    // emergency pin gets its own synchroniser; only the second flop is read
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            emg_meta_ff <= 1'b0;
            emg_sync_ff <= 1'b0;
        end
        else
        begin
            emg_meta_ff <= i_emergency_cutoff;
            emg_sync_ff <= emg_meta_ff;
        end
    end

    // a word counts only when it is strobed and addressed to this stage
    assign word_accept = i_cmd.load && i_cmd.stage_sel;

    // holding register: words for other stages leave it untouched
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            word_ff <= SCDL_WORD_RST;
        end
        else if (word_accept)
        begin
            word_ff <= i_cmd.word;
        end
    end

    // armed flag: a new load wins over a fire in the same cycle,
    // so the fresh word is never consumed before it was echoed
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            echo_valid_ff <= 1'b0;
        end
        else if (word_accept)
        begin
            echo_valid_ff <= 1'b1;
        end
        else if (i_fire_strobe)
        begin
            // echo is consumed once the word has been acted on
            echo_valid_ff <= 1'b0;
        end
    end

    // complement of the held word goes back for checking
    assign o_echo = ~word_ff;
    assign o_echo_valid = echo_valid_ff;

    // decode fires only on the timing strobe, never at load time
    scdl_decoder #(
        .CHANNELS(CHANNELS)
    ) u_decoder (
        .i_word(word_ff),
        .i_enable(i_fire_strobe && echo_valid_ff),
        .o_onehot(nxt_pulse)
    );

    // one latch per function; a pulse sets it, ground reset clears all
    // set wins over a simultaneous ground reset so a command is never lost
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_latch
            always_ff @(posedge i_clock or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    latch_ff[ch] <= 1'b0;
                end
                else if (nxt_pulse[ch])
                begin
                    latch_ff[ch] <= 1'b1;
                end
                else if (gnd_sync_ff)
                begin
                    latch_ff[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // latched outputs stand until cleared
    assign o_command = latch_ff;

    // series chain of normally closed reset contacts, one link per latch
    assign series_chain[0] = 1'b1;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_chain
            assign series_chain[ch+1] = series_chain[ch] && !latch_ff[ch];
        end
    endgenerate

    // registered so ground sees a clean level, one cycle behind the latches
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            all_reset_ff <= 1'b1;
        end
        else
        begin
            all_reset_ff <= series_chain[CHANNELS];
        end
    end
    assign o_all_reset = all_reset_ff;

    // emergency shutdown bypasses the coded path and holds until ground reset
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            shutdown_ff <= 1'b0;
        end
        else if (emg_sync_ff)
        begin
            shutdown_ff <= 1'b1;
        end
        else if (gnd_sync_ff)
        begin
            shutdown_ff <= 1'b0;
        end
    end
    assign o_engine_shutdown = shutdown_ff;
endmodule

/* File: inc/scdl_pkg.sv */
// package for the stage command decoder latch: widths, command codes, carriers
// assumes one 20 MHz clock domain; pin-level inputs are synchronised by the user module
// Contract
// - command words are exactly eight bits wide
// - store only words addressed to this stage
// - echo complement of stored word back
// - fire channel only on later timing strobe
// - decode stored word into 112 channels
// - each command pulse sets its own latch
// - set latch holds its command output active
// - ground reset clears every command latch
// - all-reset status is AND of latches clear
// - command set lists the ten named functions
// - emergency command shuts down all engines
package scdl_pkg;
    localparam int SCDL_WORD_W = 8;
    localparam int SCDL_CHANNELS = 112;
    localparam int SCDL_CH_W = 7;
    localparam logic [SCDL_WORD_W-1:0] SCDL_WORD_RST = 8'h00;
    localparam logic [SCDL_CHANNELS-1:0] SCDL_LATCH_RST = '0;
    // channel codes of the named commands
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_CAL_APPLY = 7'h00;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_CAL_REMOVE = 7'h01;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_PRESS_V2 = 7'h02;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_PRESS_V3 = 7'h03;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_PRESS_V4 = 7'h04;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_CTR_CUTOFF_EN = 7'h05;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_OUT_CUTOFF_EN = 7'h06;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_FIRING_ARM = 7'h07;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_FIRING_FIRE = 7'h08;
    localparam logic [SCDL_CH_W-1:0] SCDL_CMD_MEAS_SWITCH = 7'h09;

    // word from the flight computer
    typedef struct packed {
        logic stage_sel;
        logic load;
        logic [SCDL_WORD_W-1:0] word;
    } scdl_cmd_s;
endpackage

/* File: sim/scdl_fc_model.sv */
// flight computer model on the shared clock: sends a word, checks its echo, fires or resends
`timescale 1ns/1ps
module scdl_fc_model
    import scdl_pkg::*;
(
    input wire logic i_clock,
    input wire logic [SCDL_WORD_W-1:0] i_echo,
    output scdl_cmd_s o_cmd = '0,
    output logic o_fire = 1'b0
);
    // eight-bit words; for a word addressed to this stage the strobe only follows a good echo, otherwise it follows unchecked
    task automatic send(input logic [SCDL_WORD_W-1:0] w, input logic s, f);
        do
        begin
            @(posedge i_clock) o_cmd <= '{s, 1'b1, w};
            @(posedge i_clock) o_cmd <= '{1'b0, 1'b0, ~w}; // released lines invert, never stale
            @(negedge i_clock);
        end
        while (s && i_echo !== ~w);
        @(posedge i_clock) o_fire <= f;
        @(posedge i_clock) o_fire <= 1'b0;
        @(negedge i_clock);
    endtask
endmodule

/* File: sim/scdl_top_sva.sv */
// port checker for scdl_top, bound below onto every instance
`timescale 1ns/1ps
module scdl_top_sva import scdl_pkg::*; #(parameter int CHANNELS = SCDL_CHANNELS) (
    input wire logic i_clock, i_reset_n, i_fire_strobe, i_ground_reset, i_emergency_cutoff,
    input wire scdl_cmd_s i_cmd,
    input wire logic [SCDL_WORD_W-1:0] o_echo,
    input wire logic o_echo_valid, o_all_reset, o_engine_shutdown,
    input wire logic [CHANNELS-1:0] o_command
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    wire ld = i_cmd.load && i_cmd.stage_sel;
    wire fr = i_fire_strobe && o_echo_valid;
    a_echo_load: assert property (ld |=> o_echo == ~$past(i_cmd.word) && o_echo_valid)
        else $error("echo wrong after load");
    a_other_stage: assert property (!ld |=> $stable(o_echo))
        else $error("echo moved without addressed load");
    a_fire_sets: assert property (fr && (o_echo ^ 8'hff) < CHANNELS
        |=> o_command[~$past(o_echo)]) else $error("channel not set");
    a_fire_only: assert property (!i_fire_strobe |=> !(o_command & ~$past(o_command)))
        else $error("channel set without strobe");
    a_latch_hold: assert property (!i_ground_reset [*4] |=>
        !($past(o_command) & ~o_command)) else $error("latch dropped");
    a_ground_clear: assert property (i_ground_reset [*5] ##0 !i_fire_strobe |=>
        !o_command) else $error("latches survive ground reset");
    a_all_reset: assert property (o_all_reset == !$past(o_command))
        else $error("all-reset status wrong");
    a_shutdown: assert property (i_emergency_cutoff [*4] |=> o_engine_shutdown)
        else $error("no engine shutdown");
    c_load: cover property (ld);
    c_fire: cover property (fr);
    c_shut: cover property (o_engine_shutdown);
endmodule
bind scdl_top scdl_top_sva #(.CHANNELS(CHANNELS)) u_sva (.*);

/* File: sim/scdl_top_tb.sv */
// bench: the flight computer model drives the latch; each task judges the ports
`timescale 1ns/1ps
module scdl_top_tb;
    import scdl_pkg::*;
    logic clk = 0, rst_n = 0, gnd = 0, emer = 0, fire, ev, ar, sd;
    logic [7:0] echo, c [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 111};
    logic [111:0] co, e = '0;
    scdl_cmd_s cmd;
    int n_fail = 0, n_tests = 0;
    scdl_fc_model fc (.i_clock(clk), .i_echo(echo), .o_cmd(cmd), .o_fire(fire));
    scdl_top dut (.i_clock(clk), .i_reset_n(rst_n), .i_cmd(cmd), .i_fire_strobe(fire),
        .i_ground_reset(gnd), .i_emergency_cutoff(emer), .o_echo(echo), .o_echo_valid(ev),
        .o_command(co), .o_all_reset(ar), .o_engine_shutdown(sd));
    task automatic chk(input logic [127:0] s, x, input string n);
        n_tests++;
        n_fail += int'(s !== x);
        if (s !== x) $display("MISMATCH %s expected %h seen %h", n, x, s);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_other();
        fc.send(8'h05, 0, 1);
        chk({echo, ev, ar, sd, co}, {8'hff, 3'b010, 112'h0}, "other");
    endtask
    task automatic t_codes();
        foreach (c[i])
        begin
            fc.send(c[i], 1, 1);
            e[c[i]] = 1'b1;
            chk({echo, ev, co}, {~c[i], 1'b0, e}, "cmd");
        end
        fc.send(8'h70, 1, 1);
        fc.send(8'h14, 1, 0);
        chk({ev, ar, co}, {2'b10, e}, "hold");
    endtask
    task automatic t_pins();
        @(posedge clk) emer <= 1;
        repeat (5) @(posedge clk);
        {emer, gnd} <= 2'b01;
        @(negedge clk);
        chk(sd, 1, "shut");
        repeat (6) @(posedge clk);
        gnd <= 0;
        @(negedge clk);
        chk({sd, ar, co}, {2'b01, 112'h0}, "ground");
    endtask
    initial
        forever #25 clk = ~clk;
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(negedge clk);
        t_other();
        t_codes();
        t_pins();
        test_done();
    end
    initial
    begin
        #40000;
        n_fail++;
        test_done();
    end
endmodule
